// file: glitch_filter.sv
// glitch_filter.sv: two-flop synchroniser plus low-glitch filter for one active-low pin
// assumes: pin is asynchronous to core_clk; output idles high after reset
`timescale 1ns/1ps
`include "pse_host_cfg.svh"
module glitch_filter (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic pin_n,
   output logic      filt_n
);
   logic                     meta_q;
   logic                     sync_q;
   logic [`GLITCH_CNT_W-1:0] cnt_q;

   // first flop feeds only the second
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= pin_n;
         sync_q <= meta_q;
      end
   end

   // low must persist the full minimum width before it counts
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q  <= '0;
         filt_n <= 1'b1;
      end else if (sync_q) begin
         cnt_q  <= '0;
         filt_n <= 1'b1;
      end else if (cnt_q == `GLITCH_CNT_W'(`GLITCH_CYCLES - 1)) begin
         filt_n <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule // glitch_filter

// file: pse_host_cfg.svh
// pse_host_cfg.svh: register offsets, field positions, reset values and timing constants
// assumes: included by the glitch filter and the interface design files, core clock at 40 MHz
`ifndef PSE_HOST_CFG_SVH
`define PSE_HOST_CFG_SVH

// ****************************************
// register map
// ****************************************
`define REG_INT_MASK        8'h01
`define REG_INT_STATUS      8'h00
`define REG_PORT_PORT_RESET_PUSHBUTTON   8'h1a
`define INT_MASK_RESET      8'h80
`define INT_STATUS_RESET    8'h00
`define PB_INT_CLR_A        6
`define PB_INT_CLR_B        7

// ****************************************
// addressing
// ****************************************
`define SLAVE_ADDR_PREFIX   3'b010

// ****************************************
// timing
// ****************************************
`define CORE_CLK_MHZ        40
`define GLITCH_MIN_NS       1000
`define GLITCH_CYCLES       ((`GLITCH_MIN_NS * `CORE_CLK_MHZ + 999) / 1000)
`define GLITCH_CNT_W        6

`endif

// file: pse_host_control_interface.sv
// pse_host_control_interface.sv: reset/shutdown filtering, interrupt pin and two-wire slave
// assumes: serial clock far slower than core_clk; events come from port logic on core_clk
// Behaviour
// - low chip reset keeps ports off and registers at power-up values
// - chip reset low pulses under 1 us are ignored
// - interrupt pin pulls low on any enabled event
// - writing bit 6 or 7 of pushbutton register releases interrupt
// - interrupt mask register gates each event source
// - interrupt pin changes only between serial transactions
// - faults during a transaction wait for stop before asserting interrupt
// - slave address is 010 followed by four straps, msb first
// - serial data uses separate sense input and open-drain drive output
// - low port shutdown input forces that port off like pushbutton bit
// - shutdown input glitches under 1 us are ignored
`timescale 1ns/1ps
`include "pse_host_cfg.svh"
module pse_host_control_interface
   import pse_host_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       chip_reset_n,
   input  wire logic [3:0] port_off_n,
   input  wire logic [3:0] slave_addr_strap,
   input  wire logic       serial_clk,
   input  wire logic       serial_data_sense_in,
   input  wire logic [7:0] event_in,
   output logic            serial_data_drive_out,
   output logic            serial_data_drive_oe,
   output logic            int_out,
   output logic            int_oe,
   output logic [3:0]      port_force_off,
   output logic            chip_hold
);
   import pse_host_pkg::*;

   // ****************************************
   // reset and shutdown filtering
   // ****************************************
   logic       reset_filt_n;
   logic [3:0] off_filt_n;
   logic       core_rst;

   glitch_filter u_reset_filt (
      .core_clk (core_clk),
      .srst     (srst),
      .pin_n    (chip_reset_n),
      .filt_n   (reset_filt_n)
   );

   for (genvar p = 0; p < 4; p++) begin : g_off
      glitch_filter u_off_filt (
         .core_clk (core_clk),
         .srst     (srst),
         .pin_n    (port_off_n[p]),
         .filt_n   (off_filt_n[p])
      );
   end

   assign core_rst = srst | ~reset_filt_n;

   // ****************************************
   // serial line synchroniser and conditions
   // ****************************************
   serial_line_t meta_q;
   serial_line_t sync_q;
   serial_line_t prev_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end else begin
         meta_q <= '{scl: serial_clk, sda: serial_data_sense_in};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_rise = sync_q.scl & ~prev_q.scl;
   assign scl_fall = ~sync_q.scl & prev_q.scl;
   assign start_c  = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
   assign stop_c   = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;

   // ****************************************
   // slave state machine
   // ****************************************
   serial_state_t state_q;
   logic [7:0]    shift_q;
   logic [2:0]    bit_q;
   logic          rw_q;
   logic          busy_q;
   logic [1:0]    phase_q;      // 0 address, 1 reg pointer, 2 data
   logic [7:0]    ptr_q;
   logic          wr_stb_q;
   logic [7:0]    wr_data_q;
   logic [7:0]    rd_data;
   logic          addr_match;

   assign addr_match = (shift_q[6:0] == {`SLAVE_ADDR_PREFIX, slave_addr_strap});

   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         state_q   <= ST_IDLE;
         shift_q   <= '0;
         bit_q     <= '0;
         rw_q      <= 1'b0;
         busy_q    <= 1'b0;
         phase_q   <= '0;
         ptr_q     <= '0;
         wr_stb_q  <= 1'b0;
         wr_data_q <= '0;
      end else begin
         wr_stb_q <= 1'b0;
         if (start_c) begin
            state_q <= ST_ADDR;
            shift_q <= '0;
            bit_q   <= '0;
            busy_q  <= 1'b1;
            phase_q <= '0;
         end else if (stop_c) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
         end else begin
            case (state_q)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sync_q.sda};
                     bit_q   <= bit_q + 1'b1;
                  end
                  if (scl_fall && bit_q == '0 && shift_q != '0) begin
                     rw_q    <= shift_q[0];
                     shift_q <= {1'b0, shift_q[7:1]};
                     state_q <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  if (!addr_match && phase_q == '0 && bit_q == '0) begin
                     state_q <= ST_IGNORE;
                  end else if (scl_fall) begin
                     phase_q <= (phase_q == '0) ? 2'd1 : phase_q;
                     shift_q <= rd_data;
                     state_q <= rw_q ? ST_READ : ST_WRITE;
                  end
               end
               ST_WRITE: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sync_q.sda};
                     bit_q   <= bit_q + 1'b1;
                  end
                  if (scl_fall && bit_q == '0) begin
                     if (phase_q == 2'd1) begin
                        ptr_q   <= shift_q;
                        phase_q <= 2'd2;
                     end else begin
                        wr_stb_q  <= 1'b1;
                        wr_data_q <= shift_q;
                     end
                     state_q <= ST_RACK;
                  end
               end
               ST_RACK: begin
                  if (scl_fall) begin
                     state_q <= ST_WRITE;
                  end
               end
               ST_READ: begin
                  if (scl_fall) begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     bit_q   <= bit_q + 1'b1;
                     if (bit_q == 3'd7) begin
                        state_q <= ST_IGNORE;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // address byte: 7 bits address then rw; shift is cleared at every start
   // so the fall that ends the start cannot look like a finished byte

   // open-drain drive: low only while acking or sending a zero
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         serial_data_drive_out <= 1'b0;
         serial_data_drive_oe  <= 1'b0;
      end else begin
         serial_data_drive_out <= 1'b0;
         // held until the state leaves on a clock fall; a release while clock is high would fake a stop
         serial_data_drive_oe  <= (state_q == ST_ACK && addr_match) || state_q == ST_RACK
                                  || (state_q == ST_READ && !shift_q[7]);
      end
   end

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] mask_q;
   logic [7:0] status_q;
   logic       int_clr;

   assign int_clr = wr_stb_q && ptr_q == `REG_PORT_PORT_RESET_PUSHBUTTON
                    && (wr_data_q[`PB_INT_CLR_A] || wr_data_q[`PB_INT_CLR_B]);

   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         mask_q <= `INT_MASK_RESET;
      end else if (wr_stb_q && ptr_q == `REG_INT_MASK) begin
         mask_q <= wr_data_q;
      end
   end

   // sticky events; a new event wins over a release in the same cycle
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         status_q <= `INT_STATUS_RESET;
      end else begin
         status_q <= (int_clr ? '0 : status_q) | event_in;
      end
   end

   always_comb begin
      if (ptr_q == `REG_INT_MASK) begin
         rd_data = mask_q;
      end else if (ptr_q == `REG_INT_STATUS) begin
         rd_data = status_q;
      end else begin
         rd_data = '0;
      end
   end

   // ****************************************
   // interrupt pin
   // ****************************************
   // pin only re-evaluated while the bus is idle, so a fault mid-transfer waits for stop
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         int_oe  <= 1'b0;
         int_out <= 1'b0;
      end else if (!busy_q) begin
         int_oe  <= |(status_q & mask_q);
         int_out <= 1'b0;
      end
   end

   // ****************************************
   // port control
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         port_force_off <= '1;
         chip_hold      <= 1'b1;
      end else begin
         port_force_off <= ~off_filt_n;
         chip_hold      <= 1'b0;
      end
   end
endmodule // pse_host_control_interface

// file: pse_host_control_interface_asserts.sv
// checker for the host control interface, bound to its top module
// assumes: one clock domain, core_clk, with srst as its reset
`timescale 1ns/1ps
module pse_host_control_interface_asserts (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       chip_reset_n,
   input wire logic [3:0] port_off_n,
   input wire logic [3:0] slave_addr_strap,
   input wire logic       serial_clk,
   input wire logic       serial_data_sense_in,
   input wire logic [7:0] event_in,
   input wire logic       serial_data_drive_out,
   input wire logic       serial_data_drive_oe,
   input wire logic       int_out,
   input wire logic       int_oe,
   input wire logic [3:0] port_force_off,
   input wire logic       chip_hold
);
   logic       scl_q, sda_q, open_q, rst_n_q;
   logic [5:0] lo_cnt_q;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge core_clk) begin
      scl_q <= serial_clk;
      sda_q <= serial_data_sense_in;
      rst_n_q <= chip_reset_n;
   end
   // raw pins: the design sees them later, so only long-open spans are judged
   always_ff @(posedge core_clk) begin
      if (srst)
         open_q <= 1'b0;
      else if (scl_q && serial_clk && sda_q != serial_data_sense_in)
         open_q <= !serial_data_sense_in;
   end
   // length of the latest low run of the chip reset pin
   always_ff @(posedge core_clk) begin
      if (srst)
         lo_cnt_q <= 6'h00;
      else if (!chip_reset_n)
         lo_cnt_q <= rst_n_q ? 6'h01 : lo_cnt_q + 6'(lo_cnt_q != 6'h3f);
   end
   a_hold_ports_off: assert property (chip_hold |-> port_force_off == 4'hf && !int_oe && !serial_data_drive_oe)
      else $error("outputs active while chip held");
   a_reset_glitch: assert property ($rose(chip_hold) |-> lo_cnt_q >= 6'h28)
      else $error("chip held after short low");
   a_int_open_drain: assert property (int_out == 1'b0)
      else $error("interrupt pin driven high");
   a_int_quiet: assert property (open_q && $past(open_q, 6) |-> $stable(int_oe))
      else $error("interrupt moved inside transaction");
   a_sda_open_drain: assert property (serial_data_drive_out == 1'b0)
      else $error("data pin driven high");
   a_port_off_acts: assert property ($fell(port_off_n[2]) |-> ##[1:60] (port_force_off[2] || port_off_n[2]))
      else $error("port not forced off");
   a_port_glitch: assert property ($rose(port_force_off[2]) && !chip_hold |-> $past(port_off_n[2], 30) == 1'b0)
      else $error("port off after short low");
   a_sync_delay: assert property ($fell(chip_reset_n) && !chip_hold |=> !chip_hold [*2])
      else $error("chip hold reacted unsynchronised");
endmodule // pse_host_control_interface_asserts

// file: pse_host_pkg.sv
// pse_host_pkg.sv: types shared by the host control interface
// assumes: constants come from pse_host_cfg.svh
package pse_host_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK,
      ST_WRITE,
      ST_READ,
      ST_RACK,
      ST_IGNORE
   } serial_state_t;

   typedef struct packed {
      logic [3:0] port_off;     // per-port forced off
      logic [7:0] event_set;    // events raised this cycle
   } port_ctrl_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } serial_line_t;

endpackage

// file: serial_host_model.sv
// host controller model on the two-wire bus, 200 ns bit period
// assumes: data line pulled up, bench joins sense and drive pins
`timescale 1ns/1ps
module serial_host_model (
   output logic      scl,
   output logic      sda_oe,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // also serves as repeated start
   task automatic start();
      #50 sda_oe = 1'b0;
      #100 scl = 1'b1;
      #100 sda_oe = 1'b1;
      #100 scl = 1'b0;
   endtask
   task automatic bit_io(input logic b, output logic r);
      #50 sda_oe = !b;
      #50 scl = 1'b1;
      #50 r = sda;
      #50 scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(w[i], r[i]);
      bit_io(a, k);
   endtask
   task automatic stop();
      #50 sda_oe = 1'b1;
      #50 scl = 1'b1;
      #100 sda_oe = 1'b0;
      #100;
   endtask
endmodule // serial_host_model

// file: test_pse_host_control_interface.sv
// self-checking bench for the host control interface
// assumes: host model on the serial pins, line pulled up
`timescale 1ns/1ps
module test_pse_host_control_interface;
   import pse_host_pkg::*;
   logic       core_clk = 1'b0, srst = 1'b1, chip_reset_n = 1'b1;
   logic [3:0] port_off_n = 4'hf, strap = 4'ha, force_off;
   logic [7:0] event_in = 8'h00, rd;
   logic       scl, host_oe, sda_oe, int_oe, chip_hold, ack;
   int         n_errors = 0, comparisons = 0;
   wire        sda = !(host_oe || sda_oe);
   initial forever #12.5 core_clk = !core_clk;
   serial_host_model host (.scl(scl), .sda_oe(host_oe), .sda(sda));
   pse_host_control_interface uut (
      .core_clk, .srst, .chip_reset_n, .port_off_n, .slave_addr_strap(strap), .serial_clk(scl),
      .serial_data_sense_in(sda), .event_in, .serial_data_drive_out(), .serial_data_drive_oe(sda_oe),
      .int_out(), .int_oe, .port_force_off(force_off), .chip_hold);
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic int_is(input logic [7:0] e);
      cyc(10);
      chk(8'(int_oe), e);
   endtask
   task automatic addr(input logic rw, input logic [3:0] st, input logic a);
      host.start();
      host.xfer({3'b010, st, rw}, 1'b1, rd, ack);
      chk(8'(ack), 8'(!a));
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      addr(1'b0, strap, 1'b1);
      host.xfer(a, 1'b1, rd, ack);
      host.xfer(d, 1'b1, rd, ack);
      host.stop();
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      addr(1'b0, strap, 1'b1);
      host.xfer(a, 1'b1, rd, ack);
      addr(1'b1, strap, 1'b1);
      host.xfer(8'hff, 1'b1, rd, ack);
      host.stop();
      chk(rd, e);
   endtask
   task automatic pulse(input logic [7:0] ev);
      @(posedge core_clk) event_in <= ev;
      @(posedge core_clk) event_in <= 8'h00;
   endtask
   // one pin low for n+1 cycles, effect sampled 51 cycles after the fall
   task automatic low(input logic pin, input int n, input logic [7:0] e);
      @(posedge core_clk);
      if (pin)
         port_off_n[2] <= 1'b0;
      else
         chip_reset_n <= 1'b0;
      for (int i = 0; i < 80; i++) begin
         @(posedge core_clk);
         if (i == n) begin
            port_off_n[2] <= 1'b1;
            chip_reset_n <= 1'b1;
         end
         if (i == 50)
            #1 chk(pin ? 8'(force_off) : 8'(chip_hold), e);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ***
   // main sequence
   // ***
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      cyc(8);
      chk(8'({chip_hold, force_off, int_oe}), 8'h00);
      reg_rd(8'h01, 8'h80);
      reg_rd(8'h3c, 8'h00);
      for (int i = 0; i < 4; i++) begin
         addr(1'b0, strap ^ (4'h1 << i), 1'b0);
         host.stop();
      end
      reg_wr(8'h01, 8'h01);
      reg_rd(8'h01, 8'h01);
      pulse(8'h02);
      int_is(8'h00);
      pulse(8'h01);
      int_is(8'h01);
      reg_rd(8'h00, 8'h03);
      reg_wr(8'h1a, 8'h40);
      int_is(8'h00);
      // event raised with the bus open must wait for the stop
      addr(1'b0, strap, 1'b1);
      pulse(8'h01);
      int_is(8'h00);
      host.stop();
      int_is(8'h01);
      reg_wr(8'h1a, 8'h80);
      int_is(8'h00);
      low(1'b0, 20, 8'h00);
      low(1'b1, 20, 8'h00);
      low(1'b1, 70, 8'h04);
      low(1'b0, 70, 8'h01);
      cyc(60);
      reg_rd(8'h01, 8'h80);
      end_of_test();
   end
   initial begin
      #2ms;
      n_errors++;
      end_of_test();
   end
endmodule // test_pse_host_control_interface
bind pse_host_control_interface pse_host_control_interface_asserts u_chk (
   .core_clk, .srst, .chip_reset_n, .port_off_n, .slave_addr_strap, .serial_clk, .serial_data_sense_in,
   .event_in, .serial_data_drive_out, .serial_data_drive_oe, .int_out, .int_oe, .port_force_off, .chip_hold);
